// file: logic/dao_pkg.sv
// constants shared by the digital audio out framer and its input buffer
package dao_pkg;

    // core clock rate in hertz
    localparam int unsigned CLK_HZ = 50000000;
    // channel cells per frame: 2 subframes x 32 slots x 2 cells
    localparam int unsigned CELLS_PER_FRAME = 128;
    // sample rates in hertz
    localparam int unsigned FS_441 = 44100;
    localparam int unsigned FS_48 = 48000;
    localparam int unsigned FS_32 = 32000;
    // accumulator width and per-clock increments for the cell rate
    localparam int ACC_W = 27;
    localparam logic [26:0] ACC_MOD = 27'(CLK_HZ);
    localparam logic [26:0] INC_441 = 27'(CELLS_PER_FRAME * FS_441);
    localparam logic [26:0] INC_48 = 27'(CELLS_PER_FRAME * FS_48);
    localparam logic [26:0] INC_32 = 27'(CELLS_PER_FRAME * FS_32);

    // rate select codes on the rate_sel input
    localparam logic [1:0] RATE_441 = 2'h0;
    localparam logic [1:0] RATE_48 = 2'h1;
    localparam logic [1:0] RATE_32 = 2'h2;

    // subframe layout, in slots
    localparam logic [4:0] SLOT_PRE_END = 5'h03;
    localparam logic [4:0] SLOT_SAMPLE_LO = 5'h0c;
    localparam logic [4:0] SLOT_SAMPLE_HI = 5'h1b;
    localparam logic [4:0] SLOT_VALID = 5'h1c;
    localparam logic [4:0] SLOT_USER = 5'h1d;
    localparam logic [4:0] SLOT_STATUS = 5'h1e;
    localparam logic [4:0] SLOT_PARITY = 5'h1f;
    // frames per block, last frame index
    localparam logic [7:0] FRAME_LAST = 8'hbf;

    // preamble cell patterns after a low line level
    localparam logic [7:0] PRE_X = 8'he2;
    localparam logic [7:0] PRE_Y = 8'he4;
    localparam logic [7:0] PRE_Z = 8'he8;

    // validity value sent for a disc source
    localparam logic VALIDITY = 1'b0;
    // channel status bit positions that carry non-zero content
    localparam logic [7:0] CS_COPY = 8'h02;
    localparam logic [7:0] CS_EMPH = 8'h03;
    localparam logic [7:0] CS_CAT_MSB = 8'h08;
    localparam logic [7:0] CS_RATE0 = 8'h18;
    localparam logic [7:0] CS_RATE1 = 8'h19;

    // input buffer shape: left, right, user left, user right
    localparam int SAMPLE_W = 16;
    localparam int FIFO_W = 34;
    localparam int FIFO_D = 8;

endpackage : dao_pkg

// file: logic/audio_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module audio_fifo #(
    parameter int W = 34,
    parameter int D = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL = CW'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    // storage words
    logic [W-1:0] mem [D];
    // write and read pointers
    logic [AW-1:0] wptr_r, wptr_nxt;
    logic [AW-1:0] rptr_r, rptr_nxt;
    // fill count and registered not-full flag
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic rdy_r, rdy_nxt;
    logic push, pop;

    // handshake qualified moves
    always_comb
    begin
        push = in_valid && rdy_r;
        pop = out_ready && (cnt_r != '0);
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            wptr_nxt = (wptr_r == LAST) ? '0 : wptr_r + 1'b1;
        end
        if (pop)
        begin
            rptr_nxt = (rptr_r == LAST) ? '0 : rptr_r + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
        rdy_nxt = (cnt_nxt != FULL);
    end

    // pointer and flag registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end
        else
        begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // data array, written only on push
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wptr_r] <= in_data;
        end
    end

    assign in_ready = rdy_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rptr_r];

endmodule : audio_fifo

// file: logic/digital_audio_out_framer.sv
// biphase-mark digital audio out framer with input sample buffer
`timescale 1ns/1ns

module digital_audio_out_framer (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [1:0] rate_sel,
    input wire logic copy_permit,
    input wire logic pre_emph,
    input wire logic in_valid,
    input wire logic [15:0] in_left,
    input wire logic [15:0] in_right,
    input wire logic in_user_l,
    input wire logic in_user_r,
    output logic in_ready,
    output logic line_out,
    output logic underflow
);

    // sequencer states
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_pre = 3'b010,
        st_body = 3'b100
    } seq_state_t;

    // cell rate accumulator and its tick
    logic [26:0] acc_r, acc_nxt;
    logic tick_r, tick_nxt;
    // sequencer state and position counters
    seq_state_t state_r, state_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic half_r, half_nxt;
    logic ch_r, ch_nxt;
    logic [7:0] frame_r, frame_nxt;
    // preamble cells, line level, parity
    logic [7:0] pat_r, pat_nxt;
    logic line_r, line_nxt;
    logic par_r, par_nxt;
    logic pre_lvl_r, pre_lvl_nxt;
    // held frame samples
    logic [15:0] left_r, left_nxt;
    logic [15:0] right_r, right_nxt;
    logic ul_r, ul_nxt;
    logic ur_r, ur_nxt;
    logic unf_r, unf_nxt;
    // buffer read side
    logic buf_valid;
    logic [dao_pkg::FIFO_W-1:0] buf_data;
    logic pop;
    // combinational helpers
    logic first;
    logic [7:0] cur_pat;
    logic [2:0] cell_idx;
    logic bit_val;
    logic [15:0] smp;
    logic usr;

    // increment per core clock for the selected rate
    function automatic logic [26:0] rate_inc(input logic [1:0] r);
        unique case (r)
            dao_pkg::RATE_48: rate_inc = dao_pkg::INC_48;
            dao_pkg::RATE_32: rate_inc = dao_pkg::INC_32;
            default: rate_inc = dao_pkg::INC_441;
        endcase
    endfunction : rate_inc

    // channel status bit for one frame index of the block
    function automatic logic cs_bit(
        input logic [7:0] idx,
        input logic [1:0] r,
        input logic cp,
        input logic em
    );
        cs_bit = 1'b0;
        // consumer use, normal audio, fields default zero
        if (idx == dao_pkg::CS_COPY)
        begin
            cs_bit = cp;
        end
        else if (idx == dao_pkg::CS_EMPH)
        begin
            cs_bit = em;
        end
        else if (idx == dao_pkg::CS_CAT_MSB)
        begin
            cs_bit = 1'b1;
        end
        else if (idx == dao_pkg::CS_RATE0)
        begin
            cs_bit = (r == dao_pkg::RATE_32);
        end
        else if (idx == dao_pkg::CS_RATE1)
        begin
            cs_bit = (r == dao_pkg::RATE_48) || (r == dao_pkg::RATE_32);
        end
    endfunction : cs_bit

    // sample buffer in front of the framer
    audio_fifo #(
        .W(dao_pkg::FIFO_W),
        .D(dao_pkg::FIFO_D)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(in_valid),
        .in_data({in_left, in_right, in_user_l, in_user_r}),
        .in_ready(in_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(pop)
    );

    // cell tick: 128 cells per sample period, exact on average
    always_comb
    begin
        acc_nxt = acc_r + rate_inc(rate_sel);
        tick_nxt = 1'b0;
        if (acc_nxt >= dao_pkg::ACC_MOD)
        begin
            acc_nxt = acc_nxt - dao_pkg::ACC_MOD;
            tick_nxt = 1'b1;
        end
    end

    // accumulator registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    // next cell of the line and position advance
    always_comb
    begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        half_nxt = half_r;
        ch_nxt = ch_r;
        frame_nxt = frame_r;
        pat_nxt = pat_r;
        line_nxt = line_r;
        par_nxt = par_r;
        pre_lvl_nxt = pre_lvl_r;
        left_nxt = left_r;
        right_nxt = right_r;
        ul_nxt = ul_r;
        ur_nxt = ur_r;
        unf_nxt = 1'b0;
        pop = 1'b0;
        first = (slot_r == '0) && !half_r;
        cell_idx = {slot_r[1:0], half_r};
        smp = ch_r ? right_r : left_r;
        usr = ch_r ? ur_r : ul_r;
        // preamble kind by channel and frame index
        if (ch_r)
        begin
            cur_pat = dao_pkg::PRE_Y;
        end
        else if (frame_r == '0)
        begin
            cur_pat = dao_pkg::PRE_Z;
        end
        else
        begin
            cur_pat = dao_pkg::PRE_X;
        end
        // inverted version after a high line level
        cur_pat = first ? (cur_pat ^ {8{line_r}}) : pat_r;
        // payload bit of the current slot
        if ((slot_r >= dao_pkg::SLOT_SAMPLE_LO) &&
            (slot_r <= dao_pkg::SLOT_SAMPLE_HI))
        begin
            bit_val = smp[4'(slot_r - dao_pkg::SLOT_SAMPLE_LO)];
        end
        else if (slot_r == dao_pkg::SLOT_VALID)
        begin
            bit_val = dao_pkg::VALIDITY;
        end
        else if (slot_r == dao_pkg::SLOT_USER)
        begin
            bit_val = usr;
        end
        else if (slot_r == dao_pkg::SLOT_STATUS)
        begin
            bit_val = cs_bit(frame_r, rate_sel, copy_permit, pre_emph);
        end
        else if (slot_r == dao_pkg::SLOT_PARITY)
        begin
            bit_val = par_r;
        end
        else
        begin
            // aux slots and unused low audio slots
            bit_val = 1'b0;
        end
        if (tick_r)
        begin
            unique case (state_r)
                st_idle:
                begin
                    // line held low until the first cell tick
                    state_nxt = st_pre;
                end
                st_pre:
                begin
                    // raw preamble cells, no biphase coding
                    pat_nxt = cur_pat;
                    line_nxt = cur_pat[3'd7 - cell_idx];
                    if (first)
                    begin
                        par_nxt = 1'b0;
                    end
                    if (first && !ch_r)
                    begin
                        // one frame taken per sample period
                        pop = buf_valid;
                        unf_nxt = !buf_valid;
                        left_nxt = buf_valid ? buf_data[33:18] : '0;
                        right_nxt = buf_valid ? buf_data[17:2] : '0;
                        ul_nxt = buf_valid && buf_data[1];
                        ur_nxt = buf_valid && buf_data[0];
                    end
                    half_nxt = !half_r;
                    if (half_r)
                    begin
                        slot_nxt = slot_r + 1'b1;
                    end
                    if (half_r && (slot_r == dao_pkg::SLOT_PRE_END))
                    begin
                        state_nxt = st_body;
                        pre_lvl_nxt = line_nxt;
                    end
                end
                st_body:
                begin
                    // biphase mark: toggle at slot edge, mid toggle on 1
                    if (!half_r)
                    begin
                        line_nxt = !line_r;
                        if (slot_r != dao_pkg::SLOT_PARITY)
                        begin
                            par_nxt = par_r ^ bit_val;
                        end
                    end
                    else
                    begin
                        line_nxt = line_r ^ bit_val;
                    end
                    half_nxt = !half_r;
                    if (half_r)
                    begin
                        slot_nxt = slot_r + 1'b1;
                    end
                    if (half_r && (slot_r == dao_pkg::SLOT_PARITY))
                    begin
                        // subframe done, next channel
                        state_nxt = st_pre;
                        slot_nxt = '0;
                        ch_nxt = !ch_r;
                        if (ch_r)
                        begin
                            frame_nxt = (frame_r == dao_pkg::FRAME_LAST) ?
                                '0 : frame_r + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= st_idle;
            slot_r <= '0;
            half_r <= 1'b0;
            ch_r <= 1'b0;
            frame_r <= '0;
            pat_r <= '0;
            line_r <= 1'b0;
            par_r <= 1'b0;
            pre_lvl_r <= 1'b0;
            left_r <= '0;
            right_r <= '0;
            ul_r <= 1'b0;
            ur_r <= 1'b0;
            unf_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            half_r <= half_nxt;
            ch_r <= ch_nxt;
            frame_r <= frame_nxt;
            pat_r <= pat_nxt;
            line_r <= line_nxt;
            par_r <= par_nxt;
            pre_lvl_r <= pre_lvl_nxt;
            left_r <= left_nxt;
            right_r <= right_nxt;
            ul_r <= ul_nxt;
            ur_r <= ur_nxt;
            unf_r <= unf_nxt;
        end
    end

    // single data line, no clock beside it
    assign line_out = line_r;
    assign underflow = unf_r;

    // subframe wraps after slot 31
    chk_slot_wrap: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_body && slot_r == 5'h1f && half_r)
        |=> (slot_r == 5'h00 && state_r == st_pre && ch_r != $past(ch_r)))
        else $error("subframe did not wrap after 32 slots");

    // block wraps after frame 191
    chk_block_wrap: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_body && slot_r == 5'h1f && half_r &&
         ch_r && frame_r == 8'hbf) |=> (frame_r == 8'h00))
        else $error("block did not wrap after 192 frames");

    // block-start preamble on frame 0 channel 1
    chk_pre_block: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_pre && first && !ch_r && frame_r == 8'h00)
        |=> (pat_r == (8'he8 ^ {8{$past(line_r)}})))
        else $error("wrong block-start preamble");

    // channel 1 preamble on other frames
    chk_pre_ch1: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_pre && first && !ch_r && frame_r != 8'h00)
        |=> (pat_r == ($past(line_r) ? 8'h1d : 8'he2)))
        else $error("wrong channel 1 preamble");

    // channel 2 preamble always
    chk_pre_ch2: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_pre && first && ch_r)
        |=> (pat_r == ($past(line_r) ? 8'h1b : 8'he4)))
        else $error("wrong channel 2 preamble");

    // preamble first cell opposes the previous level
    chk_pre_raw: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_pre && first)
        |=> (line_r != $past(line_r)))
        else $error("preamble first cell not inverted");

    // slot edge always toggles in data slots
    chk_bmc_edge: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_body && !half_r)
        |=> (line_r != $past(line_r)))
        else $error("missing slot edge transition");

    // validity slot has no mid-slot toggle
    chk_valid_zero: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_body && slot_r == 5'h1c && half_r)
        |=> (line_r == $past(line_r)))
        else $error("validity slot not zero");

    // even ones: subframe ends at the level left by the preamble
    chk_parity_even: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (tick_r && state_r == st_body && slot_r == 5'h1f && half_r)
        |=> (line_r == pre_lvl_r))
        else $error("subframe parity not even");

endmodule : digital_audio_out_framer

// file: sim/dao_receiver.sv
// behavioural receiver that decodes the biphase-mark audio line
`timescale 1ns/1ns
module dao_receiver (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic line_in,
    input wire logic [1:0] rate_sel
);
    // preamble kind per subframe: 0 ch1, 1 ch2, 2 block start, 3 bad
    logic [1:0] kind_q[$];
    // decoded slots 4..31 per subframe, bit 0 is slot 4
    logic [27:0] word_q[$];
    // missing toggles at slot boundaries
    int bm_err;
    // status bits gathered per channel across a block
    logic [191:0] status_l;
    logic [191:0] status_r;
    logic [63:0] sh; // last 64 cells, oldest at the top
    logic lvl; // line level during the current run
    logic sf_prev; // line level ahead of the current subframe
    logic synced; // a preamble has been found
    int run; // clocks since the last edge
    int ncell; // cells gathered in this subframe
    int nsf; // subframes decoded
    int cell_x100; // nominal cell length in hundredths of a clock

    // cell length follows the selected sample rate
    always_comb
        cell_x100 = (rate_sel == 2'h1) ? 814 : (rate_sel == 2'h2) ? 1221 : 886;

    // add one cell; decode once a whole subframe is in
    task automatic add_cell(input logic v);
        logic [7:0] pre;
        logic [27:0] w;
        sh = {sh[62:0], v};
        ncell++;
        if (ncell < 64)
            return;
        pre = sh[63:56] ^ {8{sf_prev}};
        // the inverted pattern is expected after a high level
        kind_q.push_back(pre == 8'he2 ? 2'h0 : pre == 8'he4 ? 2'h1 :
            pre == 8'he8 ? 2'h2 : 2'h3);
        for (int s = 4; s < 32; s++)
        begin
            // every slot must open with a toggle
            if (sh[63 - 2 * s] == sh[64 - 2 * s])
                bm_err++;
            w[s - 4] = sh[63 - 2 * s] ^ sh[62 - 2 * s];
        end
        word_q.push_back(w);
        if (nsf % 2 == 1)
            status_r[(nsf / 2) % 192] = w[26];
        else
            status_l[(nsf / 2) % 192] = w[26];
        nsf++;
        sf_prev = sh[0];
        ncell = 0;
    endtask

    // measure runs between edges and turn them into cells
    always @(posedge core_clk or negedge rstn)
    begin : rx_run
        int n;
        if (!rstn)
        begin
            lvl = 1'b0;
            sf_prev = 1'b0;
            synced = 1'b0;
            run = 0;
            ncell = 0;
            nsf = 0;
            bm_err = 0;
            kind_q.delete();
            word_q.delete();
        end
        else
        begin
            run++;
            if (line_in !== lvl)
            begin
                n = (run * 100 + cell_x100 / 2) / cell_x100;
                // three high cells after idle open the first preamble
                if (!synced && lvl && n >= 3)
                    synced = 1'b1;
                for (int i = 0; i < n; i++)
                    if (synced)
                        add_cell(lvl);
                lvl = line_in;
                run = 0;
            end
        end
    end
endmodule : dao_receiver

// file: sim/digital_audio_out_framer_tb.sv
// self-checking bench for the digital audio out framer
`timescale 1ns/1ns
module digital_audio_out_framer_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] rate_sel = 2'h0;
    logic copy_permit = 1'b0;
    logic pre_emph = 1'b0;
    logic in_valid = 1'b0;
    logic [15:0] in_left = 16'h0000;
    logic [15:0] in_right = 16'h0000;
    logic in_user_l = 1'b0;
    logic in_user_r = 1'b0;
    logic in_ready;
    logic line_out;
    logic underflow;
    logic feed_en = 1'b0; // feeder offers words while set
    int nw = 0; // words taken by the buffer
    int fails = 0;
    int checked = 0;

    // 50 mhz clock
    always #10 core_clk = ~core_clk;

    digital_audio_out_framer uut (
        .core_clk(core_clk), .rstn(rstn), .rate_sel(rate_sel),
        .copy_permit(copy_permit), .pre_emph(pre_emph),
        .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
        .in_user_l(in_user_l), .in_user_r(in_user_r),
        .in_ready(in_ready), .line_out(line_out), .underflow(underflow)
    );

    dao_receiver rx (
        .core_clk(core_clk), .rstn(rstn), .line_in(line_out),
        .rate_sel(rate_sel)
    );

    // sample pattern for word n; word 0 sets both end bits on the left and clears them on the right
    function automatic logic [15:0] word_l(input int n);
        return 16'h8001 ^ 16'(n * 16'h1d3b);
    endfunction : word_l
    function automatic logic [15:0] word_r(input int n);
        return 16'h7ffe ^ 16'(n * 16'h0f5d);
    endfunction : word_r

    // feeder: holds each word until the buffer takes it
    always @(posedge core_clk)
    begin
        if (in_valid && in_ready)
            nw = nw + 1;
        in_valid <= feed_en;
        in_left <= word_l(nw);
        in_right <= word_r(nw);
        in_user_l <= nw[0];
        in_user_r <= nw[1];
    end

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // two-cycle reset with rate and status inputs; idle outputs judged
    task automatic do_reset(input logic [1:0] r, input logic cp,
        input logic em);
        @(posedge core_clk);
        rstn <= 1'b0;
        feed_en <= 1'b0;
        rate_sel <= r;
        copy_permit <= cp;
        pre_emph <= em;
        // reset stays low for two clock cycles in all
        @(posedge core_clk);
        #1;
        chk("line_out in reset", 0, line_out);
        chk("in_ready in reset", 1, in_ready);
        chk("underflow in reset", 0, underflow);
        nw = 0;
        @(posedge core_clk);
        rstn <= 1'b1;
    endtask : do_reset

    // back-to-back pushes until the buffer refuses
    task automatic t_fill;
        feed_en <= 1'b1;
        repeat (40)
        begin
            @(posedge core_clk);
            #1;
            if (nw == 8)
                break;
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk("words taken when full", 8, nw);
        chk("in_ready when full", 0, in_ready);
    endtask : t_fill

    // first frame with an empty buffer flags once, then feed starts
    task automatic t_underflow;
        repeat (200)
        begin
            @(posedge core_clk);
            #1;
            if (underflow === 1'b1)
                break;
        end
        chk("underflow pulse", 1, underflow);
        @(posedge core_clk);
        #1;
        chk("underflow after one cycle", 0, underflow);
        @(posedge core_clk);
        feed_en <= 1'b1;
    endtask : t_underflow

    // judge every subframe of nf frames; the first skip frames are silent
    task automatic t_frames(input int nf, input int skip);
        int f;
        int n;
        logic [15:0] smp;
        logic usr;
        logic cs;
        logic [27:0] w;
        logic [1:0] kd;
        for (int k = 0; k < 2 * nf; k++)
        begin
            repeat (3000)
            begin
                if (rx.word_q.size() > k)
                    break;
                @(posedge core_clk);
                #1;
            end
            if (rx.word_q.size() <= k)
            begin
                chk("subframes seen", k + 1, rx.word_q.size());
                return;
            end
            f = k / 2;
            n = f - skip;
            smp = (f < skip) ? 16'h0000 : k[0] ? word_r(n) : word_l(n);
            usr = (f >= skip) && (k[0] ? n[1] : n[0]);
            cs = (f == 2) ? copy_permit : (f == 3) ? pre_emph : (f == 8) ||
                (f == 24 && rate_sel == 2'h2) ||
                (f == 25 && rate_sel inside {2'h1, 2'h2});
            w = {1'b0, cs, usr, 1'b0, smp, 8'h00};
            w[27] = ^w[26:0];
            kd = (k == 0) ? 2'h2 : k[0] ? 2'h1 : 2'h0;
            chk("preamble kind", kd, rx.kind_q[k]);
            chk("subframe slots", w, rx.word_q[k]);
            // both channels of a frame carry the same status bit
            if (k[0])
                chk("status pair", {cs, cs}, {rx.status_l[f], rx.status_r[f]});
        end
        chk("biphase violations", 0, rx.bm_err);
    endtask : t_frames

    // main sequence: one run per sample rate
    initial
    begin
        do_reset(2'h0, 1'b1, 1'b0);
        t_fill;
        t_frames(10, 0);
        do_reset(2'h1, 1'b0, 1'b1);
        t_underflow;
        t_frames(26, 1);
        do_reset(2'h2, 1'b1, 1'b1);
        t_fill;
        t_frames(26, 0);
        test_done;
    end

    // watchdog against a hang
    initial
    begin
        // three runs of about 11k, 27k and 41k cycles, plus margin
        repeat (95000) @(posedge core_clk);
        fails++;
        $display("MISMATCH run length expected done seen hang");
        test_done;
    end
endmodule : digital_audio_out_framer_tb
